//--- tpr_pkg.sv
// Constants, register indices and field layouts for the role and test bank
package tpr_pkg;

  // Bus geometry
  localparam int TPR_ADDR_W = 16;
  localparam int TPR_DATA_W = 32;
  localparam int TPR_IDX_W = 14;
  localparam int TPR_REG_W = 16;
  localparam int TPR_LANES = 2;

  // Register indices, byte address is four times the index
  localparam logic [TPR_IDX_W-1:0] TPR_IDX_ABILITY = 14'h1012;
  localparam logic [TPR_IDX_W-1:0] TPR_IDX_ROLE_CTRL = 14'h1834;
  localparam logic [TPR_IDX_W-1:0] TPR_IDX_TEST_CTRL = 14'h1836;
  localparam logic [TPR_IDX_W-1:0] TPR_IDX_CODING_CTRL = 14'h3000;

  // Reset and fixed values
  localparam logic [TPR_REG_W-1:0] TPR_ABILITY_VALUE = 16'h0001;
  localparam logic [TPR_REG_W-1:0] TPR_ROLE_FIXED = 16'h8000;
  localparam logic [TPR_REG_W-1:0] TPR_TEST_RESET = 16'h0000;
  localparam logic [TPR_REG_W-1:0] TPR_CODING_RESET = 16'h0000;

  // Field positions
  localparam int TPR_ROLE_SEL_BIT = 14;
  localparam int TPR_TEST_MSB = 15;
  localparam int TPR_TEST_LSB = 13;
  localparam int TPR_CODING_RESET_BIT = 15;
  localparam int TPR_CODING_LOOP_BIT = 14;
  localparam int TPR_CODING_RXSTOP_BIT = 10;

  // Transmit test mode codes
  typedef enum logic [2:0] {
    TPR_TM_NORMAL = 3'b000,
    TPR_TM_MODE1 = 3'b001,
    TPR_TM_MODE2 = 3'b010,
    TPR_TM_RSVD3 = 3'b011,
    TPR_TM_MODE4 = 3'b100,
    TPR_TM_MODE5 = 3'b101,
    TPR_TM_RSVD6 = 3'b110,
    TPR_TM_RSVD7 = 3'b111
  } tpr_test_mode_t;

  // AXI response codes
  localparam logic [1:0] TPR_RESP_OKAY = 2'b00;
  localparam logic [1:0] TPR_RESP_SLVERR = 2'b10;
  localparam logic [TPR_DATA_W-1:0] TPR_DATA_ZERO = 32'h0000_0000;

endpackage

//--- tpr_strap_sync.sv
// Strap pin synchroniser and package-dependent strap selection
`timescale 1ns/1ns
`default_nettype none
module tpr_strap_sync
  import tpr_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Strap pins
  input wire logic first_led_strap_input,
  input wire logic fourth_rx_data_strap_input,
  input wire logic small_package_select,
  // Selected strap level
  output logic strap_role
);

  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic strap_reg;
  logic strap_next;

  // Straps are static pins, so the chain runs free without reset
  always_comb begin
    meta_next = {small_package_select, fourth_rx_data_strap_input,
                 first_led_strap_input};
    sync_next = meta_reg;
    // Larger package uses the LED strap, smaller one the data strap
    strap_next = sync_reg[2] ? sync_reg[1] : sync_reg[0]; // [R04]
  end

  // Two stages before anything looks at the pins
  always_ff @(posedge aclk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
    strap_reg <= strap_next;
  end

  assign strap_role = strap_reg;

endmodule
`default_nettype wire

//--- tpr_regs.sv
// Role, test-mode and coding-layer control registers behind AXI4-Lite
//
// Functional notes
// R01: The ability register resets to 0001h with bit 0 a fixed one and the rest zero.
// R02: The role control register resets to 8000h with bit 14 taken from the strap, and bit 15 always reads one.
// R03: Role bit 14 is writable, one selects link master and zero link slave.
// R04: The role bit reset value comes from the strap chosen by package size.
// R05: Role register bits 3 to 0 and 13 to 4 are read-only zero.
// R06: Test-mode bits 15 to 13 select normal or test modes 1, 2, 4, 5; software avoids reserved codes.
// R07: The test-mode register resets to 0000h and its low 13 bits are writable storage only.
// R08: The coding-layer control register sits at 3000h and resets to 0000h.
// R09: Writing one to coding bit 15 resets the coding, autonegotiation and link logic, then clears.
// R10: The coding-layer loopback bit 14 is cleared by every coding-layer soft reset.
// R11: Writes to read-only fields are ignored and reserved read-only bits read zero.
`timescale 1ns/1ns
`default_nettype none
module tpr_regs
  import tpr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [TPR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [TPR_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [TPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [TPR_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap pins
  input wire logic first_led_strap_input,
  input wire logic fourth_rx_data_strap_input,
  input wire logic small_package_select,
  // Controls to the physical layer
  output logic role_select_bit,
  output logic [2:0] transmit_test_mode,
  output logic coding_layer_loopback,
  output logic rx_clock_stoppable,
  output logic coding_layer_soft_reset
);

  // Write channel state
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [TPR_IDX_W-1:0] waddr_reg;
  logic [TPR_IDX_W-1:0] waddr_next;
  logic [TPR_REG_W-1:0] wdata_reg;
  logic [TPR_REG_W-1:0] wdata_next;
  logic [TPR_LANES-1:0] wstrb_reg;
  logic [TPR_LANES-1:0] wstrb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Read channel state
  logic rvalid_reg;
  logic rvalid_next;
  logic [TPR_DATA_W-1:0] rdata_reg;
  logic [TPR_DATA_W-1:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // Register contents
  logic role_reg;
  logic role_next;
  logic [TPR_REG_W-1:0] test_reg;
  logic [TPR_REG_W-1:0] test_next;
  logic loop_reg;
  logic loop_next;
  logic rxstop_reg;
  logic rxstop_next;
  logic soft_reset_reg;
  logic soft_reset_next;
  logic [2:0] test_out_reg;
  logic [2:0] test_out_next;

  // Helpers
  logic strap_role;
  logic do_write;
  logic [TPR_REG_W-1:0] lane_mask;
  logic [TPR_REG_W-1:0] role_view;
  logic [TPR_REG_W-1:0] coding_view;
  logic [TPR_REG_W-1:0] read_word;
  logic read_hit;
  logic write_hit;
  logic [TPR_IDX_W-1:0] raddr_idx;
  logic [2:0] test_field;

  // Strap capture path
  tpr_strap_sync u_strap (
    .aclk(aclk),
    .first_led_strap_input(first_led_strap_input),
    .fourth_rx_data_strap_input(fourth_rx_data_strap_input),
    .small_package_select(small_package_select),
    .strap_role(strap_role)
  );

  // Byte lanes widen to bit masks for the 16-bit registers
  genvar lane;
  generate
    for (lane = 0; lane < TPR_LANES; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wstrb_reg[lane]}};
    end
  endgenerate

  // A write commits once both address and data are held
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  // Handshake readies, idle only when nothing is pending
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  // Write address decode
  always_comb begin
    if (waddr_reg == TPR_IDX_ROLE_CTRL) begin
      write_hit = 1'b1;
    end else if (waddr_reg == TPR_IDX_TEST_CTRL) begin
      write_hit = 1'b1;
    end else if (waddr_reg == TPR_IDX_CODING_CTRL) begin
      write_hit = 1'b1;
    end else if (waddr_reg == TPR_IDX_ABILITY) begin
      write_hit = 1'b1;
    end else begin
      write_hit = 1'b0;
    end
  end

  // Write channel sequencing; address and data may come in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      waddr_next = s_axi_awaddr[TPR_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata[TPR_REG_W-1:0];
      wstrb_next = s_axi_wstrb[TPR_LANES-1:0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = write_hit ? TPR_RESP_OKAY : TPR_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= TPR_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Register updates; read-only fields simply have no write path
  always_comb begin
    role_next = role_reg;
    test_next = test_reg;
    loop_next = loop_reg;
    rxstop_next = rxstop_reg;
    soft_reset_next = 1'b0;
    if (!aresetn) begin
      // Strap level loads while reset is held
      role_next = strap_role; // [R04]
    end else if (do_write) begin
      if (waddr_reg == TPR_IDX_ROLE_CTRL) begin
        if (lane_mask[TPR_ROLE_SEL_BIT]) begin
          role_next = wdata_reg[TPR_ROLE_SEL_BIT]; // [R03]
        end
      end else if (waddr_reg == TPR_IDX_TEST_CTRL) begin
        // All sixteen bits store, low ones carry no function
        test_next = (wdata_reg & lane_mask) | (test_reg & ~lane_mask); // [R07]
      end else if (waddr_reg == TPR_IDX_CODING_CTRL) begin
        if (lane_mask[TPR_CODING_LOOP_BIT]) begin
          loop_next = wdata_reg[TPR_CODING_LOOP_BIT];
        end
        if (lane_mask[TPR_CODING_RXSTOP_BIT]) begin
          rxstop_next = wdata_reg[TPR_CODING_RXSTOP_BIT];
        end
        if (lane_mask[TPR_CODING_RESET_BIT] &&
            wdata_reg[TPR_CODING_RESET_BIT]) begin
          // Soft reset beats the loopback value in the same write
          soft_reset_next = 1'b1; // [R09]
          loop_next = 1'b0; // [R10]
          rxstop_next = 1'b0; // [R09]
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      role_reg <= role_next; // [R04]
      test_reg <= TPR_TEST_RESET; // [R07]
      loop_reg <= TPR_CODING_RESET[TPR_CODING_LOOP_BIT]; // [R08]
      rxstop_reg <= TPR_CODING_RESET[TPR_CODING_RXSTOP_BIT]; // [R08]
      soft_reset_reg <= 1'b0;
    end else begin
      role_reg <= role_next;
      test_reg <= test_next;
      loop_reg <= loop_next;
      rxstop_reg <= rxstop_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // Reserved codes drive normal operation so a bad write stays harmless
  assign test_field = test_reg[TPR_TEST_MSB:TPR_TEST_LSB];
  always_comb begin
    case (tpr_test_mode_t'(test_field))
      TPR_TM_MODE1: test_out_next = TPR_TM_MODE1; // [R06]
      TPR_TM_MODE2: test_out_next = TPR_TM_MODE2; // [R06]
      TPR_TM_MODE4: test_out_next = TPR_TM_MODE4; // [R06]
      TPR_TM_MODE5: test_out_next = TPR_TM_MODE5; // [R06]
      default: test_out_next = TPR_TM_NORMAL; // [R06]
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_out_reg <= TPR_TM_NORMAL;
    end else begin
      test_out_reg <= test_out_next;
    end
  end

  // Read views; fixed bits come from constants, reserved bits are zero
  always_comb begin
    role_view = TPR_ROLE_FIXED; // [R02] [R05] [R11]
    role_view[TPR_ROLE_SEL_BIT] = role_reg; // [R03]
    coding_view = TPR_CODING_RESET; // [R11]
    // Soft reset bit self-clears, so it always reads zero
    coding_view[TPR_CODING_LOOP_BIT] = loop_reg;
    coding_view[TPR_CODING_RXSTOP_BIT] = rxstop_reg;
  end

  // Read address decode
  assign raddr_idx = s_axi_araddr[TPR_ADDR_W-1:2];
  always_comb begin
    read_hit = 1'b1;
    if (raddr_idx == TPR_IDX_ABILITY) begin
      read_word = TPR_ABILITY_VALUE; // [R01]
    end else if (raddr_idx == TPR_IDX_ROLE_CTRL) begin
      read_word = role_view; // [R02] [R05]
    end else if (raddr_idx == TPR_IDX_TEST_CTRL) begin
      read_word = test_reg; // [R07]
    end else if (raddr_idx == TPR_IDX_CODING_CTRL) begin
      read_word = coding_view; // [R08]
    end else begin
      read_word = '0;
      read_hit = 1'b0;
    end
  end

  // Read channel, one answer outstanding at a time
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = {{(TPR_DATA_W-TPR_REG_W){1'b0}}, read_word};
      rresp_next = read_hit ? TPR_RESP_OKAY : TPR_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= TPR_DATA_ZERO;
      rresp_reg <= TPR_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign role_select_bit = role_reg; // [R03]
  assign transmit_test_mode = test_out_reg;
  assign coding_layer_loopback = loop_reg;
  assign rx_clock_stoppable = rxstop_reg;
  assign coding_layer_soft_reset = soft_reset_reg; // [R09]

endmodule
`default_nettype wire

//--- tpr_regs_monitor.sv
// Port checker for the role and test register bank
`timescale 1ns/1ns
`default_nettype none
module tpr_regs_monitor
  import tpr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channel
  input wire logic [TPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [TPR_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Physical layer controls
  input wire logic role_select_bit,
  input wire logic [2:0] transmit_test_mode,
  input wire logic coding_layer_loopback,
  input wire logic rx_clock_stoppable,
  input wire logic coding_layer_soft_reset
);
  logic [TPR_IDX_W-1:0] idx_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Index of the pending read, so read data can be judged per register
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      idx_reg <= s_axi_araddr[TPR_ADDR_W-1:2];
    end
  end
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  AST_ABIL_RD: assert property (
    s_axi_rvalid && idx_reg == TPR_IDX_ABILITY |->
    s_axi_rdata == 32'h0000_0001 && s_axi_rresp == TPR_RESP_OKAY)
    else $error("ability read wrong");
  AST_ROLE_RD: assert property (
    s_axi_rvalid && idx_reg == TPR_IDX_ROLE_CTRL |-> s_axi_rdata ==
    {16'h0000, 1'b1, role_select_bit, 14'h0000})
    else $error("role read disagrees with role pin");
  AST_CODE_RD: assert property (
    s_axi_rvalid && idx_reg == TPR_IDX_CODING_CTRL |-> s_axi_rdata ==
    {16'h0000, 1'b0, coding_layer_loopback, 3'b000, rx_clock_stoppable,
    10'h000})
    else $error("coding read disagrees with pins");
  AST_TM_LEGAL: assert property (transmit_test_mode inside {3'b000,
    3'b001, 3'b010, 3'b100, 3'b101})
    else $error("reserved test mode driven");
  AST_PULSE: assert property (coding_layer_soft_reset |=>
    !coding_layer_soft_reset)
    else $error("soft reset pulse longer than one cycle");
  AST_LOOP_CLR: assert property (coding_layer_soft_reset |->
    !coding_layer_loopback && !rx_clock_stoppable)
    else $error("loopback kept through soft reset");
  AST_RST_VAL: assert property ($rose(aresetn) |->
    transmit_test_mode == 3'b000 && !coding_layer_loopback &&
    !rx_clock_stoppable && !coding_layer_soft_reset && !s_axi_rvalid)
    else $error("outputs not at reset values");
endmodule
`default_nettype wire

//--- tpr_regs_tb_top.sv
// Self-checking bench for the role and test register bank
`timescale 1ns/1ns
`default_nettype none
module tpr_regs_tb_top
  import tpr_pkg::*;
;
  logic aclk, aresetn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot, transmit_test_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, role_select_bit;
  logic first_led_strap_input, fourth_rx_data_strap_input;
  logic small_package_select, coding_layer_loopback;
  logic rx_clock_stoppable, coding_layer_soft_reset;
  int bad_count, samples_checked, m_role, m_tm, m_loop, m_rxs;
  int m_pulse, pulses, cyc, rnd;
  logic [13:0] tbl [5];
  logic [13:0] ri;
  logic [31:0] rw;
  logic [2:0] codes [5];
  tpr_regs tpr_regs_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .first_led_strap_input, .fourth_rx_data_strap_input,
    .small_package_select, .role_select_bit, .transmit_test_mode,
    .coding_layer_loopback, .rx_clock_stoppable, .coding_layer_soft_reset
  );
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Cycle ceiling and soft reset pulse count
  always @(posedge aclk) begin
    cyc++;
    if (coding_layer_soft_reset === 1'b1) pulses++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e, input string w);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic chk_data(input logic [31:0] g, e); cmp(g, e, "data"); endtask
  task automatic chk_resp(input logic [31:0] g, e); cmp(g, e, "resp"); endtask
  task automatic chk_pin(input logic [31:0] g, e); cmp(g, e, "pin"); endtask
  // Bus master: payload held until each channel's own handshake edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, rh, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // Random start lets some answers wait on a low rready
    s_axi_rready <= 1'($urandom);
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rv && !rh) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask
  // Model: expected response and read word of an index
  function automatic logic [33:0] exp_rd(input logic [13:0] i);
    case (i)
      TPR_IDX_ABILITY: return {2'b00, 32'h0000_0001};
      TPR_IDX_ROLE_CTRL: return {18'h0_0000, 1'b1, m_role[0], 14'h0000};
      TPR_IDX_TEST_CTRL: return {18'h0_0000, m_tm[15:0]};
      TPR_IDX_CODING_CTRL: return {19'h0_0000, m_loop[0], 3'b000,
        m_rxs[0], 10'h000};
      default: return {TPR_RESP_SLVERR, TPR_DATA_ZERO};
    endcase
  endfunction
  // Model update; soft reset wins over loopback in the same word
  task automatic mdl_wr(input logic [13:0] i, input logic [31:0] d,
                        input logic [3:0] s);
    if (i == TPR_IDX_ROLE_CTRL && s[1]) m_role = d[14];
    if (i == TPR_IDX_TEST_CTRL && s[0]) m_tm[7:0] = d[7:0];
    if (i == TPR_IDX_TEST_CTRL && s[1]) m_tm[15:8] = d[15:8];
    if (i == TPR_IDX_CODING_CTRL && s[1]) begin
      m_loop = d[15] ? 0 : d[14];
      m_rxs = d[15] ? 0 : d[10];
      m_pulse += d[15];
    end
  endtask
  task automatic rdc(input logic [13:0] i);
    logic [31:0] d;
    logic [1:0] r;
    logic [33:0] x;
    x = exp_rd(i);
    rd({i, 2'b00}, d, r);
    chk_data(d, x[31:0]);
    chk_resp(32'(r), 32'(x[33:32]));
  endtask
  // Test mode pin shows 000 for reserved codes
  task automatic pins();
    logic [2:0] t;
    @(negedge aclk);
    t = m_tm[15:13];
    if (t == 3'b011 || t > 3'b101) t = 3'b000;
    chk_pin(32'(role_select_bit), 32'(m_role[0]));
    chk_pin(32'(transmit_test_mode), 32'(t));
    chk_pin(32'(coding_layer_loopback), 32'(m_loop[0]));
    chk_pin(32'(rx_clock_stoppable), 32'(m_rxs[0]));
    chk_pin(32'(pulses), 32'(m_pulse));
  endtask
  task automatic op(input logic [13:0] i, input logic [31:0] d,
                    input logic [3:0] s);
    logic [1:0] r;
    wr({i, 2'b00}, d, s, r);
    chk_resp(32'(r), 32'(exp_rd(i) >> 32));
    mdl_wr(i, d, s);
    rdc(i);
    pins();
  endtask
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
    {first_led_strap_input, fourth_rx_data_strap_input} = 2'b10;
    small_package_select = 1'b0;
    {bad_count, samples_checked, m_tm, m_loop, m_rxs} = '0;
    {m_pulse, pulses, cyc} = '0;
    m_role = 1;
    tbl = '{TPR_IDX_ABILITY, TPR_IDX_ROLE_CTRL, TPR_IDX_TEST_CTRL,
      TPR_IDX_CODING_CTRL, 14'h0100};
    // Legal test-mode codes only; software keeps off the reserved ones
    codes = '{TPR_TM_NORMAL, TPR_TM_MODE1, TPR_TM_MODE2, TPR_TM_MODE4,
      TPR_TM_MODE5};
    rnd = $urandom(98498);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 5; k++) rdc(tbl[k]);
    pins();
    for (int c = 0; c < 8; c++) begin
      op(TPR_IDX_TEST_CTRL, {16'h0000, codes[c % 5], 13'($urandom)},
         4'h3);
    end
    op(TPR_IDX_TEST_CTRL, $urandom, 4'h1);
    op(TPR_IDX_ROLE_CTRL, 32'hFFFF_FFFF, 4'hF);
    op(TPR_IDX_ROLE_CTRL, 32'h0000_0000, 4'hF);
    op(TPR_IDX_ROLE_CTRL, 32'h0000_4000, 4'h1);
    op(TPR_IDX_ABILITY, 32'hFFFF_FFFE, 4'hF);
    op(TPR_IDX_CODING_CTRL, 32'h0000_4400, 4'h3);
    op(TPR_IDX_CODING_CTRL, 32'h0000_C400, 4'h3);
    op(TPR_IDX_CODING_CTRL, 32'h0000_4400, 4'h2);
    op(TPR_IDX_CODING_CTRL, 32'h0000_8000, 4'h1);
    op(TPR_IDX_CODING_CTRL, 32'h0000_8000, 4'h2);
    for (int n = 0; n < 30; n++) begin
      ri = tbl[$urandom % 5];
      rw = $urandom;
      if (ri == TPR_IDX_TEST_CTRL) rw[15:13] = codes[$urandom % 5];
      op(ri, rw, 4'($urandom));
    end
    // Mid-run reset with the small package strap selected
    small_package_select <= 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    {m_role, m_tm, m_loop, m_rxs} = '0;
    for (int k = 0; k < 5; k++) rdc(tbl[k]);
    pins();
    results();
  end
endmodule
bind tpr_regs tpr_regs_monitor tpr_regs_monitor_i (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .role_select_bit, .transmit_test_mode, .coding_layer_loopback,
  .rx_clock_stoppable, .coding_layer_soft_reset);
`default_nettype wire
